// ==== rtl/host_serial_access_port.sv ====
// host serial access port: spi slave, i2c target and mode byte decoder
// assumes register bank, fifo and passive store answer reads
// combinationally on the request outputs; serial pins are asynchronous
`timescale 1ns/1ps

// How it works
// R1: write: mode byte, address, data, auto-increment
// R2: write byte committed at its last falling edge
// R3: writes to absent or read-only registers dropped
// R4: register read streams bytes, address advancing
// R5: absent register reads back as zero
// R6: prefix fbh selects page b until deselect
// R7: fifo load sends one to 512 bytes
// R8: fifo read streams while clocked and selected
// R9: direct command starts at select rising edge
// R10: master waits while long command runs
// R11: completion of long command raises interrupt
// R12: immediate command may chain in one frame
// R13: passive store load fills consecutive addresses
// R14: master keeps load within area size
// R15: i2c target answers at address 50h
// R16: i2c works up to 3.4 mhz
// R17: i2c write uses spi mode byte, increments
// R18: i2c register read streams, zeros when absent
// R19: i2c fbh prefix selects page until stop
// R20: transparent mode ends select low plus scl
// R21: bare i2c read gives ffh then registers
// R22: i2c fifo read streams while master reads
// R23: top two mode bits select the operation
// R24: passive loads start 0, 15, 36; read 0
// R25: spi samples falling, shifts out rising
// R26: miso floats whenever no read data
// R27: command strobe out, busy until done
module host_serial_access_port
  import host_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic i2c_en,
  input wire logic sclk,
  input wire logic port_select_n,
  input wire logic mosi,
  input wire logic miso_i,
  output logic miso_q,
  output logic miso_oe_q,
  output logic sda_oe_q,
  output reg_req_t reg_req_q,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_exists,
  input wire logic reg_writable,
  output mem_req_t mem_req_q,
  input wire logic [7:0] fifo_rdata,
  input wire logic [7:0] pt_rdata,
  output logic [7:0] wdata_q,
  output cmd_t cmd_q,
  input wire logic cmd_done,
  input wire logic cmd_notify,
  output logic busy_q,
  output logic irq_q,
  output logic transparent_q
);

  function automatic logic is_read(input dec_state_t s);
    is_read = (s == D_RD) || (s == D_FRD) || (s == D_PRD);
  endfunction

  // ---------------- spi, link clock domain ----------------
  logic [2:0] sbit_q;
  logic [6:0] sshift_q;
  logic [7:0] srx_q;
  logic stgl_q;
  logic [7:0] stx_q;
  tx_word_t tx_hold_q;

  // deselect clears the bit position, so every frame starts aligned
  always_ff @(negedge sclk or posedge port_select_n) begin
    if (port_select_n) begin
      sbit_q <= 3'h0;
      sshift_q <= 7'h00;
    end else begin
      sbit_q <= sbit_q + 3'h1; // R25
      sshift_q <= {sshift_q[5:0], mosi}; // R1
    end
  end

  // byte word stays put for eight bits; the toggle hands it over
  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      srx_q <= 8'h00;
      stgl_q <= 1'b0;
    end else if (!port_select_n && sbit_q == 3'h7) begin
      srx_q <= {sshift_q, mosi}; // R2
      stgl_q <= ~stgl_q;
    end
  end

  // tx_hold_q is settled by the system side between bytes
  always_ff @(posedge sclk or posedge port_select_n) begin
    if (port_select_n) begin
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0; // R26
      stx_q <= 8'h00;
    end else if (sbit_q == 3'h0) begin
      miso_q <= tx_hold_q.data[7]; // R4
      miso_oe_q <= tx_hold_q.valid; // R26
      stx_q <= {tx_hold_q.data[6:0], 1'b0};
    end else begin
      miso_q <= stx_q[7]; // R25
      stx_q <= {stx_q[6:0], 1'b0};
    end
  end

  // ---------------- system clock domain ----------------
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] prev_q;

  assign sync_in = {i2c_en, stgl_q, miso_i, sclk, port_select_n};

  // oversampling covers high-speed scl at 40 mhz
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
      prev_q <= SYNC_RST;
    end else if (ce) begin
      meta_q <= sync_in; // R16
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic i2c_s, sel_s, scl_s, sda_s;
  logic scl_rise, scl_fall, i_start, i_stop, i_live;
  logic spi_start, spi_end, spi_byte;
  logic i2c_byte, i2c_probe, i2c_take;
  logic ev_byte, ev_end, ev_take;
  logic [7:0] ev_data;
  i2c_state_t ist_q;
  dec_state_t dec_q;
  logic [3:0] icnt_q;
  logic [7:0] ishift_q;
  logic [7:0] tshift_q;
  logic irw_q, iack_q;
  logic fetch_q, inc_q, pend_q;
  logic [5:0] pend_code_q;

  assign i2c_s = sync_q[S_I2C];
  assign sel_s = sync_q[S_SEL];
  assign scl_s = sync_q[S_SCL];
  assign sda_s = sync_q[S_SDA];
  assign scl_rise = scl_s && !prev_q[S_SCL];
  assign scl_fall = !scl_s && prev_q[S_SCL];
  assign i_start = scl_s && prev_q[S_SCL] && prev_q[S_SDA] && !sda_s;
  assign i_stop = scl_s && prev_q[S_SCL] && !prev_q[S_SDA] && sda_s;
  assign i_live = i2c_s && !transparent_q && !i_start && !i_stop;

  assign spi_start = !i2c_s && prev_q[S_SEL] && !sel_s;
  assign spi_end = !i2c_s && !prev_q[S_SEL] && sel_s;
  assign spi_byte = !i2c_s && (sync_q[S_TGL] ^ prev_q[S_TGL]);

  assign i2c_byte = i_live && ist_q == I_RX && scl_fall && icnt_q == 4'h8;
  assign i2c_probe = i_live && ist_q == I_ADDR && scl_fall && icnt_q == 4'h8
                     && ishift_q == {I2C_TARGET_ADDR, 1'b1} && !busy_q;
  assign i2c_take = i_live && ist_q == I_TACK && scl_rise && !sda_s;

  assign ev_byte = spi_byte || i2c_byte;
  assign ev_data = i2c_s ? ishift_q : srx_q;
  assign ev_end = spi_end || (i2c_s && i_stop);
  assign ev_take = is_read(dec_q) && (i2c_take || spi_byte);

  // i2c target engine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ist_q <= I_IDLE;
      icnt_q <= 4'h0;
      ishift_q <= 8'h00;
      tshift_q <= 8'h00;
      irw_q <= 1'b0;
      iack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      if (!i2c_s || transparent_q) begin
        ist_q <= I_IDLE;
        sda_oe_q <= 1'b0;
      end else if (i_start) begin
        ist_q <= I_ADDR;
        icnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (i_stop) begin
        ist_q <= I_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (ist_q)
          I_ADDR, I_RX: begin
            if (scl_rise) begin
              ishift_q <= {ishift_q[6:0], sda_s};
              icnt_q <= icnt_q + 4'h1;
            end else if (scl_fall && icnt_q == 4'h8) begin
              icnt_q <= 4'h0;
              if (ist_q == I_RX) begin
                sda_oe_q <= 1'b1; // R17
                ist_q <= I_RACK;
              // no answer while a long command runs
              end else if (ishift_q[7:1] == I2C_TARGET_ADDR && !busy_q) begin
                sda_oe_q <= 1'b1; // R15
                irw_q <= ishift_q[0];
                ist_q <= I_AACK;
              end else begin
                ist_q <= I_IDLE; // R10
              end
            end
          end
          I_AACK, I_RACK: begin
            if (scl_fall) begin
              if (ist_q == I_AACK && irw_q) begin
                tshift_q <= tx_hold_q.data;
                sda_oe_q <= ~tx_hold_q.data[7]; // R18
                ist_q <= I_TX;
              end else begin
                sda_oe_q <= 1'b0;
                ist_q <= I_RX;
              end
            end
          end
          I_TX: begin
            if (scl_rise) begin
              icnt_q <= icnt_q + 4'h1;
            end else if (scl_fall) begin
              if (icnt_q == 4'h8) begin
                sda_oe_q <= 1'b0;
                icnt_q <= 4'h0;
                ist_q <= I_TACK;
              end else begin
                tshift_q <= {tshift_q[6:0], 1'b0};
                sda_oe_q <= ~tshift_q[6];
              end
            end
          end
          I_TACK: begin
            if (scl_rise) begin
              iack_q <= ~sda_s;
            end else if (scl_fall) begin
              if (iack_q) begin
                tshift_q <= tx_hold_q.data;
                sda_oe_q <= ~tx_hold_q.data[7]; // R22
                ist_q <= I_TX;
              end else begin
                ist_q <= I_IDLE;
              end
            end
          end
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end

  // mode byte decoder, shared by both interfaces
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dec_q <= D_MODE;
      reg_req_q <= '0;
      mem_req_q <= '0;
      wdata_q <= 8'h00;
      cmd_q <= '0;
      fetch_q <= 1'b0;
      inc_q <= 1'b0;
      pend_q <= 1'b0;
      pend_code_q <= 6'h00;
    end else if (ce) begin
      reg_req_q.wr <= 1'b0;
      mem_req_q.fifo_wr <= 1'b0;
      mem_req_q.fifo_rd <= 1'b0;
      mem_req_q.pt_wr <= 1'b0;
      cmd_q.strobe <= 1'b0;
      fetch_q <= ev_take && !ev_end;
      inc_q <= 1'b0;
      if (inc_q) begin
        reg_req_q.addr <= reg_req_q.addr + 6'h01; // R1
        mem_req_q.pt_addr <= mem_req_q.pt_addr + 7'h01; // R13
      end
      if (fetch_q) begin
        if (dec_q == D_FRD) begin
          mem_req_q.fifo_rd <= 1'b1; // R8
        end else begin
          inc_q <= 1'b1; // R4
        end
      end
      if (ev_end) begin
        cmd_q.strobe <= pend_q; // R9
        cmd_q.code <= pend_code_q;
        pend_q <= 1'b0;
        dec_q <= D_MODE;
        reg_req_q.page <= 1'b0; // R6 R19
      end else if (i2c_probe && dec_q == D_MODE) begin
        reg_req_q.addr <= PROBE_FIRST_REG; // R21
        dec_q <= D_RD;
      end else if (ev_byte) begin
        case (dec_q)
          D_MODE: begin
            // a following mode byte releases a chained command
            if (pend_q) begin
              cmd_q.strobe <= 1'b1; // R12
              cmd_q.code <= pend_code_q;
              pend_q <= 1'b0;
            end
            if (ev_data == PAGE_B_PREFIX) begin
              reg_req_q.page <= 1'b1; // R6 R19
            end else begin
              case (ev_data[7:6]) // R23
                MODE_REG_WR: begin
                  reg_req_q.addr <= ev_data[5:0]; // R17
                  dec_q <= D_WR;
                end
                MODE_REG_RD: begin
                  reg_req_q.addr <= ev_data[5:0];
                  dec_q <= D_RD;
                  fetch_q <= 1'b1;
                end
                MODE_MEM: begin
                  case (ev_data[5:0])
                    SUB_FIFO_LOAD: dec_q <= D_FLOAD;
                    SUB_FIFO_READ: begin
                      dec_q <= D_FRD; // R22
                      fetch_q <= 1'b1;
                    end
                    SUB_PT_A: begin
                      mem_req_q.pt_addr <= PT_BASE_A; // R24
                      dec_q <= D_PLOAD;
                    end
                    SUB_PT_F: begin
                      mem_req_q.pt_addr <= PT_BASE_F; // R24
                      dec_q <= D_PLOAD;
                    end
                    SUB_PT_TSN: begin
                      mem_req_q.pt_addr <= PT_BASE_TSN; // R24
                      dec_q <= D_PLOAD;
                    end
                    SUB_PT_READ: begin
                      mem_req_q.pt_addr <= PT_BASE_A; // R24
                      dec_q <= D_PRD;
                      fetch_q <= 1'b1;
                    end
                    default: dec_q <= D_MODE;
                  endcase
                end
                default: begin
                  pend_q <= 1'b1; // R9
                  pend_code_q <= ev_data[5:0];
                end
              endcase
            end
          end
          D_WR: begin
            reg_req_q.wr <= reg_writable; // R3
            wdata_q <= ev_data; // R2
            inc_q <= 1'b1;
          end
          D_FLOAD: begin
            mem_req_q.fifo_wr <= 1'b1; // R7
            wdata_q <= ev_data;
          end
          D_PLOAD: begin
            mem_req_q.pt_wr <= 1'b1; // R13
            wdata_q <= ev_data;
            inc_q <= 1'b1;
          end
          default: dec_q <= dec_q;
        endcase
      end
    end
  end

  // read data staged for whichever interface is serving
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_hold_q <= '0;
    end else if (ce) begin
      if (ev_end) begin
        tx_hold_q <= '0; // R26
      end else if (i2c_probe && dec_q == D_MODE) begin
        tx_hold_q <= '{valid: 1'b1, data: PROBE_BYTE}; // R21
      end else if (fetch_q) begin
        tx_hold_q.valid <= 1'b1;
        case (dec_q)
          D_RD: tx_hold_q.data <= reg_exists ? reg_rdata : 8'h00; // R5 R18
          D_FRD: tx_hold_q.data <= fifo_rdata;
          default: tx_hold_q.data <= pt_rdata;
        endcase
      end
    end
  end

  // busy and completion notice; a completion beats the frame clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      if (cmd_q.strobe) begin
        busy_q <= 1'b1; // R27
      end else if (cmd_done) begin
        busy_q <= 1'b0;
      end
      if (busy_q && cmd_done && cmd_notify) begin
        irq_q <= 1'b1; // R11
      end else if (spi_start || (i2c_s && i_start)) begin
        irq_q <= 1'b0;
      end
    end
  end

  // the serial lines belong to the front end until released
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      transparent_q <= 1'b0;
    end else if (ce) begin
      if (cmd_q.strobe && cmd_q.code == CMD_TRANSPARENT) begin
        transparent_q <= 1'b1;
      end else if (transparent_q && !sel_s && scl_rise) begin
        transparent_q <= 1'b0; // R20
      end
    end
  end

endmodule

// ==== rtl/host_port_pkg.sv ====
// constants, codes and carrier types of the host serial access port
// assumes a 40 MHz system clock; shared by the port and its bench
package host_port_pkg;

  localparam int PT_AW = 7;
  localparam int MCLK_KHZ = 40000;
  localparam int I2C_HS_KHZ = 3400;
  // system clock samples per high-speed scl half period
  localparam int I2C_HALF_SAMPLES = MCLK_KHZ / (2 * I2C_HS_KHZ);

  localparam logic [1:0] MODE_REG_WR = 2'h0;
  localparam logic [1:0] MODE_REG_RD = 2'h1;
  localparam logic [1:0] MODE_MEM = 2'h2;
  localparam logic [1:0] MODE_CMD = 2'h3;

  localparam logic [5:0] SUB_FIFO_LOAD = 6'h00;
  localparam logic [5:0] SUB_FIFO_READ = 6'h1f;
  localparam logic [5:0] SUB_PT_A = 6'h20;
  localparam logic [5:0] SUB_PT_F = 6'h28;
  localparam logic [5:0] SUB_PT_TSN = 6'h2c;
  localparam logic [5:0] SUB_PT_READ = 6'h3f;

  localparam logic [PT_AW-1:0] PT_BASE_A = 7'h00;
  localparam logic [PT_AW-1:0] PT_BASE_F = 7'h0f;
  localparam logic [PT_AW-1:0] PT_BASE_TSN = 7'h24;

  localparam logic [7:0] PAGE_B_PREFIX = 8'hfb;
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h50;
  localparam logic [7:0] PROBE_BYTE = 8'hff;
  localparam logic [5:0] PROBE_FIRST_REG = 6'h01;
  localparam logic [5:0] CMD_TRANSPARENT = 6'h1c;

  // synchroniser lanes and their idle reset levels
  localparam int SYNC_W = 5;
  localparam int S_SEL = 0;
  localparam int S_SCL = 1;
  localparam int S_SDA = 2;
  localparam int S_TGL = 3;
  localparam int S_I2C = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 5'h07;

  typedef struct packed {
    logic wr;
    logic page;
    logic [5:0] addr;
  } reg_req_t;

  typedef struct packed {
    logic fifo_wr;
    logic fifo_rd;
    logic pt_wr;
    logic [PT_AW-1:0] pt_addr;
  } mem_req_t;

  typedef struct packed {
    logic strobe;
    logic [5:0] code;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tx_word_t;

  typedef enum logic [6:0] {
    D_MODE = 7'h01,
    D_WR = 7'h02,
    D_RD = 7'h04,
    D_FLOAD = 7'h08,
    D_FRD = 7'h10,
    D_PLOAD = 7'h20,
    D_PRD = 7'h40
  } dec_state_t;

  typedef enum logic [6:0] {
    I_IDLE = 7'h01,
    I_ADDR = 7'h02,
    I_AACK = 7'h04,
    I_RX = 7'h08,
    I_RACK = 7'h10,
    I_TX = 7'h20,
    I_TACK = 7'h40
  } i2c_state_t;

endpackage

// ==== tb/host_port_sva.sv ====
// assertions on the host port request strobes, command flags and miso
// assumes binding to host_serial_access_port; holds in either mode
`timescale 1ns/1ps
module host_port_sva
  import host_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic port_select_n,
  input wire logic miso_oe_q,
  input wire reg_req_t reg_req_q,
  input wire logic reg_writable,
  input wire mem_req_t mem_req_q,
  input wire cmd_t cmd_q,
  input wire logic cmd_done,
  input wire logic cmd_notify,
  input wire logic busy_q,
  input wire logic irq_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // address of the last committed write, to judge the increment
  logic [5:0] wr_addr_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_addr_q <= 6'h00;
    end else if (reg_req_q.wr) begin
      wr_addr_q <= reg_req_q.addr;
    end
  end

  a_wr_single: assert property (reg_req_q.wr |=> !reg_req_q.wr)
    else $error("write strobe longer than one cycle");
  a_wr_allowed: assert property (reg_req_q.wr |-> reg_writable)
    else $error("write strobe to a protected register");
  a_addr_step: assert property (reg_req_q.wr |=> ##[0:2]
    reg_req_q.addr == wr_addr_q + 6'h01)
    else $error("address did not advance after write");
  a_cmd_pulse: assert property (cmd_q.strobe |=> !cmd_q.strobe)
    else $error("command strobe longer than one cycle");
  a_busy_follows: assert property (cmd_q.strobe |=> busy_q)
    else $error("busy missing after command strobe");
  a_busy_ends: assert property (busy_q && cmd_done |=> !busy_q)
    else $error("busy held after completion");
  a_irq_raise: assert property (
    busy_q && cmd_done && cmd_notify |=> irq_q)
    else $error("no interrupt after long command");
  a_irq_cause: assert property ($rose(irq_q) |->
    $past(cmd_done) && $past(cmd_notify))
    else $error("interrupt without long command completion");
  a_miso_float: assert property (port_select_n |-> !miso_oe_q)
    else $error("miso driven while deselected");
  a_one_strobe: assert property ($onehot0({reg_req_q.wr,
    mem_req_q.fifo_wr, mem_req_q.fifo_rd, mem_req_q.pt_wr}))
    else $error("two operation strobes at once");
endmodule

bind host_serial_access_port host_port_sva u_sva (
  .mclk(mclk), .rstn(rstn), .port_select_n(port_select_n),
  .miso_oe_q(miso_oe_q), .reg_req_q(reg_req_q),
  .reg_writable(reg_writable), .mem_req_q(mem_req_q), .cmd_q(cmd_q),
  .cmd_done(cmd_done), .cmd_notify(cmd_notify), .busy_q(busy_q),
  .irq_q(irq_q)
);

// ==== tb/spi_host_model.sv ====
// spi and i2c master standing in for the host microcontroller
// assumes miso_pin floats when undriven, pulled up in i2c mode
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk,
  output logic port_select_n,
  output logic mosi,
  output logic sda_low,
  input wire logic miso_pin
);
  // a rising select clears the link-side shifter before any frame
  initial begin
    sclk = 1'b0;
    port_select_n = 1'b0;
    mosi = 1'b0;
    sda_low = 1'b0;
    #1;
    port_select_n = 1'b1;
  end

  task automatic start;
    #40;
    port_select_n = 1'b0;
    #40;
  endtask

  // 12 ns link clock runs only inside a frame, idles low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b1;
      mosi = tx[i];
      #6;
      rx[i] = miso_pin;
      sclk = 1'b0;
      #6;
    end
    // gap lets the port stage the next read byte
    #200;
  endtask

  task automatic stop;
    port_select_n = 1'b1;
    mosi = ~mosi;
    #100;
  endtask

  // i2c: sda only moves while scl is low; 300 ns bit time
  task automatic i2c_bit(input logic b, output logic r);
    #40;
    sda_low = !b;
    #110;
    sclk = 1'b1;
    #150;
    r = miso_pin;
    sclk = 1'b0;
  endtask

  task automatic i2c_xfer(input logic [7:0] tx, input logic ack,
                          output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--)
      i2c_bit(tx[i], rx[i]);
    i2c_bit(!ack, ak);
  endtask

  task automatic i2c_start;
    sclk = 1'b1;
    #150;
    sda_low = 1'b1;
    #150;
    sclk = 1'b0;
  endtask

  task automatic i2c_stop;
    #40;
    sda_low = 1'b1;
    #110;
    sclk = 1'b1;
    #150;
    sda_low = 1'b0;
    #300;
  endtask

  // select low then one scl pulse hands the lines back to the port
  task automatic i2c_wake;
    port_select_n = 1'b0;
    #150;
    sclk = 1'b0;
    #150;
    sclk = 1'b1;
    #150;
    port_select_n = 1'b1;
    #150;
  endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the host serial access port, spi and i2c
// assumes spi_host_model as master; bank, fifo and executor are stubs
`timescale 1ns/1ps
module tb_top;
  import host_port_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_done = 1'b0;
  logic cmd_notify = 1'b0;
  logic sclk, port_select_n, mosi, miso_q, miso_oe_q, busy_q, irq_q;
  logic sda_low, sda_oe_q, transparent_q;
  logic i2c_en = 1'b0;
  logic [7:0] wdata_q, rx, p;
  reg_req_t reg_req_q;
  mem_req_t mem_req_q;
  cmd_t cmd_q;
  int bad_count = 0;
  int checked = 0;
  int ncmd = 0;
  int cnt = 0;
  logic [7:0] pops = 8'h00;
  logic [5:0] last_cmd = 6'h00;
  logic [15:0] ev_log[$];
  // open-drain sda with pull-up shares the miso pin in i2c mode
  wire sda_pin = (sda_oe_q || sda_low) ? 1'b0 : 1'b1;
  wire miso_pin = miso_oe_q ? miso_q : i2c_en ? sda_pin : 1'bz;
  // 20h..3fh absent, 06h read-only; absent reads give junk on purpose
  wire logic reg_exists = reg_req_q.addr < 6'h20;
  wire logic reg_writable = reg_exists && reg_req_q.addr != 6'h06;
  wire logic [7:0] reg_rdata = reg_exists ?
    {reg_req_q.page, 1'b1, reg_req_q.addr} : 8'h5a;
  wire logic [7:0] fifo_rdata = 8'h40 + pops;
  wire logic [7:0] pt_rdata = {1'b1, mem_req_q.pt_addr};

  always #12.5 mclk = ~mclk;

  spi_host_model u_host (
    .sclk(sclk), .port_select_n(port_select_n), .mosi(mosi),
    .sda_low(sda_low), .miso_pin(miso_pin)
  );

  host_serial_access_port u_dut (
    .mclk(mclk), .rstn(rstn), .ce(1'b1), .i2c_en(i2c_en), .sclk(sclk),
    .port_select_n(port_select_n), .mosi(mosi), .miso_i(sda_pin),
    .miso_q(miso_q), .miso_oe_q(miso_oe_q), .sda_oe_q(sda_oe_q),
    .reg_req_q(reg_req_q), .reg_rdata(reg_rdata),
    .reg_exists(reg_exists), .reg_writable(reg_writable),
    .mem_req_q(mem_req_q), .fifo_rdata(fifo_rdata), .pt_rdata(pt_rdata),
    .wdata_q(wdata_q), .cmd_q(cmd_q), .cmd_done(cmd_done),
    .cmd_notify(cmd_notify), .busy_q(busy_q), .irq_q(irq_q),
    .transparent_q(transparent_q)
  );

  // log every write strobe; fake executor finishes 20 cycles after a command strobe
  always @(posedge mclk) begin
    if (reg_req_q.wr)
      ev_log.push_back({2'b00, reg_req_q.addr, wdata_q});
    if (mem_req_q.fifo_wr)
      ev_log.push_back({8'h40, wdata_q});
    if (mem_req_q.pt_wr)
      ev_log.push_back({1'b1, mem_req_q.pt_addr, wdata_q});
    if (mem_req_q.fifo_rd)
      pops <= pops + 8'h01;
    if (cmd_q.strobe) begin
      ncmd <= ncmd + 1;
      last_cmd <= cmd_q.code;
    end
    cnt <= cmd_q.strobe ? 20 : (cnt > 0 ? cnt - 1 : 0);
    cmd_done <= cnt == 1;
    cmd_notify <= cnt == 1 && last_cmd == 6'h13;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic frame(input logic [7:0] b[]);
    u_host.start();
    foreach (b[i])
      u_host.xfer(b[i], rx);
    u_host.stop();
  endtask

  task automatic rd_frame(input logic [7:0] h[], input logic [7:0] e[]);
    u_host.start();
    foreach (h[i])
      u_host.xfer(h[i], rx);
    foreach (e[i]) begin
      u_host.xfer(8'h00, rx);
      chk(rx, e[i]);
    end
    u_host.stop();
  endtask

  // look just after the edge, once its updates have settled
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic log_is(input logic [15:0] e[]);
    settle(4);
    chk(ev_log.size(), e.size());
    foreach (e[i])
      if (i < ev_log.size())
        chk(ev_log[i], e[i]);
    ev_log.delete();
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_q !== 1'b0 && n < 100) begin
      settle(1);
      n++;
    end
    if (busy_q !== 1'b0) begin
      bad_count++;
      $display("unexpected at %0t: busy never cleared", $time);
      results();
    end
  endtask

  task automatic t_regs;
    frame('{8'h04, 8'ha5, 8'h3c, 8'h77, 8'h11});
    log_is('{16'h04a5, 16'h053c, 16'h0711});
    rd_frame('{8'h5e}, '{8'h5e, 8'h5f, 8'h00});
    rd_frame('{8'hfb, 8'h41}, '{8'hc1, 8'hc2});
    rd_frame('{8'h41}, '{8'h41});
    $display("register test done");
  endtask

  task automatic t_mem;
    frame('{8'h80, 8'h11, 8'h22});
    log_is('{16'h4011, 16'h4022});
    p = pops;
    rd_frame('{8'h9f}, '{8'h40 + p, 8'h41 + p, 8'h42 + p});
    // two bytes each keep inside every area
    frame('{8'ha0, 8'h01, 8'h02});
    frame('{8'ha8, 8'h03, 8'h04});
    frame('{8'hac, 8'h05, 8'h06});
    log_is('{16'h8001, 16'h8102, 16'h8f03, 16'h9004,
      16'ha405, 16'ha506});
    rd_frame('{8'hbf}, '{8'h80, 8'h81});
    $display("memory test done");
  endtask

  task automatic t_cmd;
    ncmd = 0;
    u_host.start();
    u_host.xfer(8'hd3, rx);
    settle(8);
    chk(ncmd, 0);
    u_host.stop();
    settle(6);
    chk(ncmd, 1);
    chk(last_cmd, 6'h13);
    chk(busy_q, 1'b1);
    wait_idle();
    chk(irq_q, 1'b1);
    ncmd = 0;
    u_host.start();
    u_host.xfer(8'hd1, rx);
    u_host.xfer(8'h45, rx);
    chk(ncmd, 1);
    u_host.xfer(8'h00, rx);
    chk(rx, 8'h45);
    u_host.stop();
    wait_idle();
    chk(irq_q, 1'b0);
    chk(last_cmd, 6'h11);
    $display("command test done");
  endtask

  task automatic t_i2c;
    logic ak;
    @(posedge mclk);
    i2c_en <= 1'b1;
    settle(4);
    u_host.i2c_start();
    u_host.i2c_xfer(8'ha0, 1'b0, rx, ak);
    chk(ak, 1'b0);
    u_host.i2c_xfer(8'h09, 1'b0, rx, ak);
    u_host.i2c_xfer(8'h3c, 1'b0, rx, ak);
    chk(ak, 1'b0);
    u_host.i2c_stop();
    log_is('{16'h093c});
    u_host.i2c_start();
    u_host.i2c_xfer(8'ha1, 1'b0, rx, ak);
    u_host.i2c_xfer(8'hff, 1'b1, rx, ak);
    chk(rx, 8'hff);
    u_host.i2c_xfer(8'hff, 1'b0, rx, ak);
    chk(rx, 8'h41);
    u_host.i2c_stop();
    u_host.i2c_start();
    u_host.i2c_xfer(8'ha0, 1'b0, rx, ak);
    u_host.i2c_xfer(8'hdc, 1'b0, rx, ak);
    u_host.i2c_stop();
    settle(6);
    chk(transparent_q, 1'b1);
    wait_idle();
    u_host.i2c_start();
    u_host.i2c_xfer(8'ha0, 1'b0, rx, ak);
    u_host.i2c_stop();
    chk(ak, 1'b1);
    u_host.i2c_wake();
    settle(2);
    chk(transparent_q, 1'b0);
    u_host.i2c_start();
    u_host.i2c_xfer(8'ha0, 1'b0, rx, ak);
    u_host.i2c_stop();
    chk(ak, 1'b0);
    $display("i2c test done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_mem();
    t_cmd();
    t_i2c();
    results();
  end
endmodule
